// >>> rtl/svlc_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module svlc_top (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [svlc_pkg::AW-1:0]    reg_addr,
  input  wire logic [svlc_pkg::DW-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [svlc_pkg::DW-1:0]         reg_rdata,
  input  wire logic                      bit_strobe,
  input  wire svlc_pkg::svlc_line_t      rx_line,
  output svlc_pkg::svlc_line_t           tx_line,
  output logic                           signaling_active,
  input  wire logic                      viol_symbol,
  input  wire logic                      code_error,
  input  wire logic                      link_active,
  input  wire logic                      gap_valid,
  input  wire logic [svlc_pkg::MIN_W-1:0] gap_pairs,
  output logic [svlc_pkg::DW-1:0]         event_flags
);
  // ==========================================================
  // Address decode
  // ==========================================================
  wire hit_tx    = (reg_addr == svlc_pkg::ADDR_TX_VEC);
  wire hit_len   = (reg_addr == svlc_pkg::ADDR_VEC_LEN);
  wire hit_lim   = (reg_addr == svlc_pkg::ADDR_LE_LIMIT);
  wire hit_ctrl  = (reg_addr == svlc_pkg::ADDR_CTRL);
  wire hit_rcv   = (reg_addr == svlc_pkg::ADDR_RCV_VEC);
  wire hit_ev    = (reg_addr == svlc_pkg::ADDR_EVENTS);
  wire hit_viol  = (reg_addr == svlc_pkg::ADDR_VIOL);
  wire hit_idle  = (reg_addr == svlc_pkg::ADDR_IDLE);
  wire hit_lecnt = (reg_addr == svlc_pkg::ADDR_LE_CNT);
  wire hit_rw    = hit_tx || hit_len || hit_lim || hit_ctrl;
  wire hit_ro    = hit_rcv || hit_ev || hit_viol || hit_idle || hit_lecnt;

  wire busy;
  wire wr_tx_ok  = reg_wr && hit_tx && !busy;
  wire wr_len_ok = reg_wr && hit_len && !busy;
  wire wr_locked = reg_wr && (hit_tx || hit_len) && busy;
  wire wr_ro     = reg_wr && !hit_rw;
  wire rd_bad    = reg_rd && !(hit_rw || hit_ro);
  wire rd_ev     = reg_rd && hit_ev;
  wire rd_viol   = reg_rd && hit_viol;
  wire rd_idle   = reg_rd && hit_idle;
  wire rd_lecnt  = reg_rd && hit_lecnt;

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [svlc_pkg::VEC_W-1:0] tx_vec_q;
  logic [svlc_pkg::VEC_W-1:0] tx_vec_d;
  logic [svlc_pkg::LEN_W-1:0] len_q;
  logic [svlc_pkg::LEN_W-1:0] len_d;
  logic [svlc_pkg::CNT_W-1:0] limit_q;
  logic [svlc_pkg::CNT_W-1:0] limit_d;
  logic [1:0]                 ctrl_q;
  logic [1:0]                 ctrl_d;

  assign tx_vec_d = wr_tx_ok ? reg_wdata : tx_vec_q;
  assign len_d    = wr_len_ok ? reg_wdata[svlc_pkg::LEN_W-1:0] : len_q; // RULE1 RULE2
  assign limit_d  = (reg_wr && hit_lim) ? reg_wdata[svlc_pkg::CNT_W-1:0] : limit_q; // RULE19
  assign ctrl_d   = (reg_wr && hit_ctrl) ? reg_wdata[1:0] : ctrl_q;

  wire viol_sel_wrap = ctrl_q[svlc_pkg::CTRL_VIOL_SEL];
  wire idle_sel_full = ctrl_q[svlc_pkg::CTRL_IDLE_SEL];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_vec_q <= '0;
      len_q    <= '0;
      limit_q  <= '0;
      ctrl_q   <= '0;
    end
    else
    begin
      tx_vec_q <= tx_vec_d;
      len_q    <= len_d;
      limit_q  <= limit_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // ==========================================================
  // Bit signaling
  // ==========================================================
  wire [svlc_pkg::VEC_W-1:0] rcv_vec;

  svlc_sig_seq u_sig (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (wr_tx_ok),
    .len        (len_q),
    .tx_vec     (tx_vec_d),
    .bit_strobe (bit_strobe),
    .rx_line    (rx_line),
    .busy       (busy),
    .rcv_vec    (rcv_vec),
    .tx_line    (tx_line)
  );

  // ==========================================================
  // Violation symbol counter
  // ==========================================================
  logic [svlc_pkg::CNT_W-1:0] viol_q;
  logic [svlc_pkg::CNT_W-1:0] viol_d;
  wire  [svlc_pkg::CNT_W-1:0] viol_base = rd_viol ? '0 : viol_q; // RULE7 RULE21

  assign viol_d = viol_base + {7'h00, viol_symbol}; // RULE8
  wire viol_ev = viol_symbol && (!viol_sel_wrap || viol_base == svlc_pkg::CNT_TOP); // RULE9

  // ==========================================================
  // Link error monitor
  // ==========================================================
  logic [svlc_pkg::CNT_W-1:0] le_q;
  logic [svlc_pkg::CNT_W-1:0] le_d;
  wire  le_event = link_active && (viol_symbol || code_error); // RULE18
  wire  [svlc_pkg::CNT_W-1:0] le_base = rd_lecnt ? '0 : le_q; // RULE15 RULE21

  assign le_d = le_base + {7'h00, le_event}; // RULE17
  wire le_ev = le_event && (le_d == limit_q); // RULE16

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      viol_q <= '0;
      le_q   <= '0;
    end
    else
    begin
      viol_q <= viol_d;
      le_q   <= le_d;
    end
  end

  // ==========================================================
  // Idle gap monitor
  // ==========================================================
  wire [svlc_pkg::IDLE_W-1:0] idle_field;
  wire                        idle_ev;

  svlc_idle_mon u_idle (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clr       (rd_idle), // RULE10
    .gap_valid (gap_valid),
    .gap_pairs (gap_pairs),
    .sel_full  (idle_sel_full),
    .field     (idle_field),
    .event_set (idle_ev)
  );

  // ==========================================================
  // Event flags, set wins over clearing read
  // ==========================================================
  logic [svlc_pkg::DW-1:0] flags_q;
  logic [svlc_pkg::DW-1:0] flags_d;
  logic [svlc_pkg::DW-1:0] flags_set;

  always_comb
  begin
    flags_set = '0;
    flags_set[svlc_pkg::EV_HOST_ERR] = wr_locked || wr_ro || rd_bad; // RULE1
    flags_set[svlc_pkg::EV_LE]       = le_ev;
    flags_set[svlc_pkg::EV_IDLE]     = idle_ev;
    flags_set[svlc_pkg::EV_VIOL]     = viol_ev;
  end

  assign flags_d = (rd_ev ? '0 : flags_q) | flags_set;

  // ==========================================================
  // Read mux
  // ==========================================================
  logic [svlc_pkg::DW-1:0] rdata_d;
  logic [svlc_pkg::DW-1:0] rdata_q;

  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      case (1'b1)
        hit_tx:    rdata_d = tx_vec_q;
        hit_len:   rdata_d = {12'h000, len_q}; // RULE2
        hit_lim:   rdata_d = {8'h00, limit_q}; // RULE19
        hit_ctrl:  rdata_d = {14'h0, ctrl_q};
        hit_rcv:   rdata_d = rcv_vec; // RULE5
        hit_ev:    rdata_d = flags_q;
        hit_viol:  rdata_d = {8'h00, viol_q}; // RULE7
        hit_idle:  rdata_d = {9'h0, idle_field}; // RULE10
        hit_lecnt: rdata_d = {8'h00, le_q}; // RULE15
        default:   rdata_d = '0;
      endcase
    end
  end

  logic                       sig_q;
  logic [svlc_pkg::LEN_W-1:0] sent_q;
  logic [svlc_pkg::LEN_W-1:0] sent_d;

  // Own bit count, mirrors the sequencer without reaching into it
  assign sent_d = wr_tx_ok ? '0 : ((busy && bit_strobe) ? sent_q + 4'h1 : sent_q);
  wire   sig_last = (sent_q == len_q); // RULE3

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= '0;
      rdata_q <= '0;
      sig_q   <= 1'b0;
      sent_q  <= '0;
    end
    else
    begin
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      sig_q   <= wr_tx_ok || (busy && !(bit_strobe && sig_last));
      sent_q  <= sent_d;
    end
  end

  assign reg_rdata        = rdata_q;
  assign event_flags      = flags_q;
  assign signaling_active = sig_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_LEN_LOCK: assert property ( // RULE1
    reg_wr && hit_len && busy |=> len_q == $past(len_q) && flags_q[svlc_pkg::EV_HOST_ERR])
    else $error("Locked length write not refused");
  AST_LEN_UPPER: assert property ( // RULE2
    reg_rd && hit_len |=> reg_rdata[15:4] == 12'h000)
    else $error("Length upper bits not zero");
  AST_VIOL_CLR: assert property ( // RULE7
    rd_viol && !viol_symbol |=> viol_q == 8'h00 && reg_rdata[15:8] == 8'h00)
    else $error("Violation counter not cleared");
  AST_VIOL_INC: assert property ( // RULE8
    !rd_viol && viol_symbol |=> viol_q == $past(viol_q) + 8'h01)
    else $error("Violation counter did not step");
  AST_VIOL_EV: assert property ( // RULE9
    viol_symbol && !viol_sel_wrap |=> flags_q[svlc_pkg::EV_VIOL])
    else $error("Violation event not flagged");
  AST_IDLE_UPPER: assert property ( // RULE10
    rd_idle |=> reg_rdata[15:7] == 9'h0)
    else $error("Idle monitor upper bits not zero");
  AST_LE_EV: assert property ( // RULE16
    le_event && !rd_lecnt && le_q + 8'h01 == limit_q |=> flags_q[svlc_pkg::EV_LE])
    else $error("Link error threshold event missed");
  AST_LE_WRAP: assert property ( // RULE17
    le_q == svlc_pkg::CNT_TOP && le_event && !rd_lecnt |=> le_q == 8'h00)
    else $error("Link error counter did not wrap");
  AST_KEEP: assert property ( // RULE21
    rd_viol && viol_symbol |=> viol_q == 8'h01)
    else $error("Event lost on clearing read");
  AST_LIMIT_UPPER: assert property ( // RULE19
    reg_rd && hit_lim |=> reg_rdata[15:8] == 8'h00)
    else $error("Limit upper bits not zero");

  COV_SIGNAL: cover property (wr_tx_ok ##[1:64] !busy);
  COV_VIOL_WRAP: cover property (viol_symbol && viol_q == svlc_pkg::CNT_TOP);
  COV_LE_HIT: cover property (le_ev);
  COV_IDLE_EV: cover property (idle_ev);
endmodule : svlc_top

// >>> rtl/svlc_pkg.sv
// Overview of operation
// RULE1: Signal bit count writes during signaling are dropped and flag a host access error
// RULE2: Signal bit count bits 15 to 4 ignore writes and read as zero
// RULE3: Count field holds vector bits minus one, 0 to 15 meaning 1 to 16
// RULE4: Incoming bit n is captured while bit n is sent, Halt one, Master zero
// RULE5: Received vector fills from bit 0 upward to the count; it is read-only
// RULE6: Host must treat the received vector as partial while signaling runs
// RULE7: Violation counter clears on read and reset, 8 bits, upper byte zero
// RULE8: Violation counter steps once per decoded violation symbol
// RULE9: Violation event on each step or on wrap at 256; counter wraps
// RULE10: Idle gap monitor clears on read and reset, upper 9 bits zero
// RULE11: Bits 6 to 4 hold smallest idle pair count, coded, starting at seven
// RULE12: Idle gap event sets when the minimum drops to a smaller value
// RULE13: Bits 3 to 0 count minimum occurrences, coded, from one, saturating at sixteen
// RULE14: Idle gap event on each occurrence step or on reaching sixteen
// RULE15: Link error counter is 8 bits, clears on read and reset, upper zero
// RULE16: Link error threshold event sets when counter equals limit; counting goes on
// RULE17: Link error counter wraps past 255 to zero without saturating
// RULE18: Link error events are detected on the active link and counted
// RULE19: Link error limit holds 8 bits, resets to zero, upper bits read zero
// RULE20: Outgoing bits go out as Halt for one, Master for zero, bit 0 first
// RULE21: An event coinciding with a clearing read stays counted after the clear
package svlc_pkg;

  localparam int AW = 8;
  localparam int DW = 16;
  localparam int LEN_W = 4;
  localparam int VEC_W = 16;
  localparam int CNT_W = 8;
  localparam int MIN_W = 3;
  localparam int OCC_W = 5;
  localparam int IDLE_W = 7;

  // Register offsets
  localparam logic [AW-1:0] ADDR_TX_VEC   = 8'h03;
  localparam logic [AW-1:0] ADDR_VEC_LEN  = 8'h04;
  localparam logic [AW-1:0] ADDR_LE_LIMIT = 8'h05;
  localparam logic [AW-1:0] ADDR_CTRL     = 8'h10;
  localparam logic [AW-1:0] ADDR_RCV_VEC  = 8'h16;
  localparam logic [AW-1:0] ADDR_EVENTS   = 8'h17;
  localparam logic [AW-1:0] ADDR_VIOL     = 8'h18;
  localparam logic [AW-1:0] ADDR_IDLE     = 8'h19;
  localparam logic [AW-1:0] ADDR_LE_CNT   = 8'h1A;

  // Event flag and control bit positions
  localparam int EV_HOST_ERR = 15;
  localparam int EV_LE       = 13;
  localparam int EV_IDLE     = 12;
  localparam int EV_VIOL     = 11;
  localparam int CTRL_VIOL_SEL = 0;
  localparam int CTRL_IDLE_SEL = 1;

  // Reset and limit values
  localparam logic [MIN_W-1:0] MIN_RESET = 3'h7;
  localparam logic [OCC_W-1:0] OCC_RESET = 5'h01;
  localparam logic [OCC_W-1:0] OCC_MAX   = 5'h10;
  localparam logic [CNT_W-1:0] CNT_TOP   = 8'hFF;

  typedef struct packed {
    logic halt;
    logic master;
  } svlc_line_t;

  typedef enum logic [1:0] {
    SVLC_IDLE = 2'b01,
    SVLC_SEND = 2'b10
  } svlc_sig_state_t;

  function automatic logic [2:0] enc_min(input logic [MIN_W-1:0] v);
    case (v)
      3'h7:    enc_min = 3'h4;
      3'h6:    enc_min = 3'h5;
      3'h5:    enc_min = 3'h7;
      3'h4:    enc_min = 3'h6;
      3'h3:    enc_min = 3'h2;
      3'h2:    enc_min = 3'h3;
      3'h1:    enc_min = 3'h1;
      default: enc_min = 3'h0;
    endcase
  endfunction : enc_min

  function automatic logic [3:0] enc_occ(input logic [OCC_W-1:0] v);
    case (v)
      5'h02:   enc_occ = 4'h8;
      5'h03:   enc_occ = 4'hC;
      5'h04:   enc_occ = 4'h4;
      5'h05:   enc_occ = 4'h5;
      5'h06:   enc_occ = 4'h7;
      5'h07:   enc_occ = 4'hF;
      5'h08:   enc_occ = 4'hE;
      5'h09:   enc_occ = 4'hA;
      5'h0A:   enc_occ = 4'h2;
      5'h0B:   enc_occ = 4'h3;
      5'h0C:   enc_occ = 4'h1;
      5'h0D:   enc_occ = 4'h9;
      5'h0E:   enc_occ = 4'hD;
      5'h0F:   enc_occ = 4'h6;
      5'h10:   enc_occ = 4'hB;
      default: enc_occ = 4'h0;
    endcase
  endfunction : enc_occ

endpackage : svlc_pkg

// >>> rtl/svlc_sig_seq.sv
`timescale 1ns/1ps
module svlc_sig_seq (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire logic [svlc_pkg::LEN_W-1:0] len,
  input  wire logic [svlc_pkg::VEC_W-1:0] tx_vec,
  input  wire logic                      bit_strobe,
  input  wire svlc_pkg::svlc_line_t      rx_line,
  output logic                           busy,
  output logic [svlc_pkg::VEC_W-1:0]     rcv_vec,
  output svlc_pkg::svlc_line_t           tx_line
);
  svlc_pkg::svlc_sig_state_t         state_q;
  svlc_pkg::svlc_sig_state_t         state_d;
  logic [svlc_pkg::LEN_W-1:0]        idx_q;
  logic [svlc_pkg::LEN_W-1:0]        idx_d;
  logic [svlc_pkg::VEC_W-1:0]        rcv_q;
  logic [svlc_pkg::VEC_W-1:0]        rcv_d;
  svlc_pkg::svlc_line_t              tx_q;
  svlc_pkg::svlc_line_t              tx_d;
  logic                              last_bit;

  assign last_bit = (idx_q == len);

  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    rcv_d   = rcv_q;
    tx_d    = '0;
    case (state_q)
      svlc_pkg::SVLC_IDLE:
      begin
        if (start)
        begin
          state_d = svlc_pkg::SVLC_SEND;
          idx_d   = '0;
          rcv_d   = '0;
        end
      end
      svlc_pkg::SVLC_SEND:
      begin
        if (bit_strobe)
        begin
          rcv_d[idx_q] = rx_line.halt; // RULE4 RULE5
          if (last_bit) // RULE3
            state_d = svlc_pkg::SVLC_IDLE;
          else
            idx_d = idx_q + 4'h1;
        end
      end
      default: state_d = svlc_pkg::SVLC_IDLE;
    endcase
    if (state_d == svlc_pkg::SVLC_SEND)
    begin
      tx_d.halt   = tx_vec[idx_d]; // RULE20
      tx_d.master = ~tx_vec[idx_d];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= svlc_pkg::SVLC_IDLE;
      idx_q   <= '0;
      rcv_q   <= '0;
      tx_q    <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
      rcv_q   <= rcv_d;
      tx_q    <= tx_d;
    end
  end

  assign busy    = (state_q == svlc_pkg::SVLC_SEND);
  assign rcv_vec = rcv_q;
  assign tx_line = tx_q;

  AST_RCV_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    busy && bit_strobe |=> rcv_q[$past(idx_q)] == $past(rx_line.halt))
    else $error("Received bit not captured");
  AST_TX_CODE: assert property (@(posedge ref_clk) disable iff (rst) // RULE20
    busy |-> tx_q.halt == tx_vec[idx_q] && tx_q.master == !tx_vec[idx_q])
    else $error("Outgoing line state wrong");
endmodule : svlc_sig_seq

// >>> rtl/svlc_idle_mon.sv
`timescale 1ns/1ps
module svlc_idle_mon (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clr,
  input  wire logic                      gap_valid,
  input  wire logic [svlc_pkg::MIN_W-1:0] gap_pairs,
  input  wire logic                      sel_full,
  output logic [svlc_pkg::IDLE_W-1:0]    field,
  output logic                           event_set
);
  logic [svlc_pkg::MIN_W-1:0] min_q;
  logic [svlc_pkg::MIN_W-1:0] min_d;
  logic [svlc_pkg::OCC_W-1:0] occ_q;
  logic [svlc_pkg::OCC_W-1:0] occ_d;
  logic [svlc_pkg::MIN_W-1:0] min_base;
  logic [svlc_pkg::OCC_W-1:0] occ_base;
  logic                       drop;
  logic                       step;

  // Clearing read restarts from reset values, event applied on top
  assign min_base = clr ? svlc_pkg::MIN_RESET : min_q; // RULE21
  assign occ_base = clr ? svlc_pkg::OCC_RESET : occ_q;
  assign drop = gap_valid && (gap_pairs < min_base); // RULE11
  assign step = gap_valid && (gap_pairs == min_base) && (occ_base != svlc_pkg::OCC_MAX);
  assign min_d = drop ? gap_pairs : min_base;
  assign occ_d = drop ? svlc_pkg::OCC_RESET : (step ? occ_base + 5'h01 : occ_base); // RULE13
  assign event_set = drop || (step && (!sel_full || occ_d == svlc_pkg::OCC_MAX)); // RULE12 RULE14
  assign field = {svlc_pkg::enc_min(min_q), svlc_pkg::enc_occ(occ_q)}; // RULE11 RULE13

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      min_q <= svlc_pkg::MIN_RESET;
      occ_q <= svlc_pkg::OCC_RESET;
    end
    else
    begin
      min_q <= min_d;
      occ_q <= occ_d;
    end
  end

  AST_MIN_DROP: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    gap_valid && gap_pairs < min_q && !clr |-> event_set ##1 min_q == $past(gap_pairs))
    else $error("Minimum drop missed");
  AST_OCC_SAT: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    occ_q == svlc_pkg::OCC_MAX && !clr && !(gap_valid && gap_pairs < min_q)
    |=> occ_q == svlc_pkg::OCC_MAX)
    else $error("Occurrence count left saturation");
endmodule : svlc_idle_mon

// >>> dv/svlc_peer_model.sv
`timescale 1ns/1ps
// ==========================================
// Neighbour station answering bit signaling
module svlc_peer_model (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire svlc_pkg::svlc_line_t tx_line,
  input  wire logic                 signaling_active,
  input  wire logic [15:0]          reply,
  input  wire logic [2:0]           gap,
  output logic                      bit_strobe,
  output svlc_pkg::svlc_line_t      rx_line,
  output logic [15:0]               got
);
  logic [3:0] idx;
  logic [2:0] cnt;
  logic       tog;

  // Halt for one, Master for zero; changing junk between frames
  assign rx_line = signaling_active ? {reply[idx], ~reply[idx]} : {tog, ~tog};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {idx, cnt, tog, bit_strobe, got} <= '0;
    else
    begin
      tog        <= ~tog;
      bit_strobe <= 1'b0;
      if (!signaling_active)
      begin
        idx <= '0;
        cnt <= '0;
      end
      else if (bit_strobe)
      begin
        got[idx] <= tx_line.halt;
        idx      <= idx + 4'h1;
        cnt      <= '0;
      end
      else if (tx_line.halt | tx_line.master)
      begin
        cnt        <= cnt + 3'h1;
        bit_strobe <= (cnt == gap);
      end
    end
  end
endmodule : svlc_peer_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [7:0]           reg_addr = '0;
  logic [15:0]          reg_wdata = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [15:0]          reg_rdata;
  logic                 bit_strobe;
  svlc_pkg::svlc_line_t rx_line;
  svlc_pkg::svlc_line_t tx_line;
  logic                 signaling_active;
  logic                 viol_symbol = 1'b0;
  logic                 code_error = 1'b0;
  logic                 link_active = 1'b0;
  logic                 gap_valid = 1'b0;
  logic [2:0]           gap_pairs = '0;
  logic [15:0]          event_flags;
  logic [15:0]          reply = '0;
  logic [2:0]           gap = 3'h3;
  logic [15:0]          got;
  logic [15:0]          d;
  logic [15:0]          tv;
  logic [3:0]           len;
  logic [2:0]           g [20];
  logic                 sel;
  logic                 e;
  int                   n;
  int                   k;
  int                   n_mismatch = 0;
  int                   checked = 0;
  localparam logic [2:0] MC [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
  localparam logic [3:0] OC [16] = '{4'h0, 4'h8, 4'hC, 4'h4, 4'h5, 4'h7, 4'hF, 4'hE,
                                     4'hA, 4'h2, 4'h3, 4'h1, 4'h9, 4'hD, 4'h6, 4'hB};

  always #4 ref_clk = ~ref_clk;

  svlc_top u_svlc_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_strobe(bit_strobe), .rx_line(rx_line), .tx_line(tx_line),
    .signaling_active(signaling_active), .viol_symbol(viol_symbol),
    .code_error(code_error), .link_active(link_active), .gap_valid(gap_valid),
    .gap_pairs(gap_pairs), .event_flags(event_flags));

  svlc_peer_model u_svlc_peer_model (.ref_clk(ref_clk), .rst(rst), .tx_line(tx_line),
    .signaling_active(signaling_active), .reply(reply), .gap(gap),
    .bit_strobe(bit_strobe), .rx_line(rx_line), .got(got));

  // ==========================================
  // Bus cycles and comparisons
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] s);
    checked++;
    if (s !== ex)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] ex);
    logic [15:0] v;
    rd(a, v);
    chk(nm, ex, v);
  endtask : rchk

  task automatic evchk(input string nm, input int b, input logic ex);
    logic [15:0] v;
    rd(svlc_pkg::ADDR_EVENTS, v);
    chk(nm, 16'(ex), 16'(v[b]));
  endtask : evchk

  // Held high for cnt cycles, one event per cycle
  task automatic ev(input logic v, input logic c, input int cnt);
    @(posedge ref_clk);
    viol_symbol <= v;
    code_error  <= c;
    repeat (cnt) @(posedge ref_clk);
    viol_symbol <= 1'b0;
    code_error  <= 1'b0;
  endtask : ev

  function automatic logic [15:0] idle_exp(input int cnt, input logic s, output logic ev_o);
    int m;
    int o;
    m    = 7;
    o    = 1;
    ev_o = 1'b0;
    for (int i = 0; i < cnt; i++)
    begin
      if (g[i] < m)
        {m, o, ev_o} = {32'(g[i]), 32'd1, 1'b1};
      else if (g[i] == m && o < 16)
      begin
        o++;
        ev_o |= !s || o == 16;
      end
    end
    return {9'h0, MC[m], OC[o - 1]};
  endfunction : idle_exp

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    #(8 * 20000);
    n_mismatch++;
    close_out();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(87));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("len_rst", svlc_pkg::ADDR_VEC_LEN, 16'h0000);
    rchk("limit_rst", svlc_pkg::ADDR_LE_LIMIT, 16'h0000);
    rchk("rcv_rst", svlc_pkg::ADDR_RCV_VEC, 16'h0000);
    rchk("viol_rst", svlc_pkg::ADDR_VIOL, 16'h0000);
    rchk("idle_rst", svlc_pkg::ADDR_IDLE, 16'h0040);
    rchk("le_rst", svlc_pkg::ADDR_LE_CNT, 16'h0000);
    d = 16'($urandom);
    wr(svlc_pkg::ADDR_LE_LIMIT, d);
    rchk("limit", svlc_pkg::ADDR_LE_LIMIT, {8'h00, d[7:0]});
    wr(svlc_pkg::ADDR_RCV_VEC, 16'hFFFF);
    evchk("err_ro", svlc_pkg::EV_HOST_ERR, 1'b1);
    rchk("rcv_ro", svlc_pkg::ADDR_RCV_VEC, 16'h0000);
    rchk("unmapped", 8'h1F, 16'h0000);
    evchk("err_unmapped", svlc_pkg::EV_HOST_ERR, 1'b1);
    $display("test registers done");
    for (int t = 0; t < 5; t++)
    begin
      len = (t == 0) ? 4'h0 : (t == 1) ? 4'hF : 4'($urandom);
      tv  = 16'($urandom);
      wr(svlc_pkg::ADDR_VEC_LEN, {12'($urandom), len});
      reply <= 16'($urandom);
      gap   <= 3'(3 + $urandom % 4);
      rchk("len", svlc_pkg::ADDR_VEC_LEN, {12'h000, len});
      rd(svlc_pkg::ADDR_EVENTS, d);
      wr(svlc_pkg::ADDR_TX_VEC, tv);
      wr(svlc_pkg::ADDR_VEC_LEN, {12'h000, ~len});
      k = 0;
      while (signaling_active !== 1'b0 && k < 300)
      begin
        @(posedge ref_clk);
        k++;
      end
      chk("sig_end", 16'h0000, 16'(k >= 300));
      evchk("err_busy", svlc_pkg::EV_HOST_ERR, 1'b1);
      rchk("len_kept", svlc_pkg::ADDR_VEC_LEN, {12'h000, len});
      d = 16'((17'h00001 << (len + 1)) - 17'h00001);
      rchk("rcv_vec", svlc_pkg::ADDR_RCV_VEC, reply & d);
      chk("tx_bits", tv & d, got & d);
    end
    $display("test signaling done");
    rd(svlc_pkg::ADDR_EVENTS, d);
    wr(svlc_pkg::ADDR_CTRL, 16'h0000);
    n = 1 + $urandom % 20;
    ev(1'b1, 1'b0, n);
    #1 chk("flag_out", 16'h0001, 16'(event_flags[svlc_pkg::EV_VIOL]));
    rchk("viol_cnt", svlc_pkg::ADDR_VIOL, 16'(n));
    rchk("viol_clr", svlc_pkg::ADDR_VIOL, 16'h0000);
    rchk("le_no_link", svlc_pkg::ADDR_LE_CNT, 16'h0000);
    evchk("ev_step", svlc_pkg::EV_VIOL, 1'b1);
    wr(svlc_pkg::ADDR_CTRL, 16'h0001);
    wr(svlc_pkg::ADDR_LE_LIMIT, 16'h0000);
    link_active <= 1'b1;
    ev(1'b1, 1'b0, 255);
    rd(svlc_pkg::ADDR_EVENTS, d);
    chk("ev_viol_255", 16'h0000, 16'(d[svlc_pkg::EV_VIOL]));
    chk("ev_le_255", 16'h0000, 16'(d[svlc_pkg::EV_LE]));
    ev(1'b1, 1'b0, 1);
    rd(svlc_pkg::ADDR_EVENTS, d);
    chk("ev_viol_wrap", 16'h0001, 16'(d[svlc_pkg::EV_VIOL]));
    chk("ev_le_wrap", 16'h0001, 16'(d[svlc_pkg::EV_LE]));
    rchk("viol_wrap", svlc_pkg::ADDR_VIOL, 16'h0000);
    rchk("le_wrap", svlc_pkg::ADDR_LE_CNT, 16'h0000);
    wr(svlc_pkg::ADDR_LE_LIMIT, 16'h0003);
    rd(svlc_pkg::ADDR_EVENTS, d);
    ev(1'b0, 1'b1, 2);
    evchk("ev_le_2", svlc_pkg::EV_LE, 1'b0);
    ev(1'b0, 1'b1, 3);
    evchk("ev_le_3", svlc_pkg::EV_LE, 1'b1);
    rchk("le_past", svlc_pkg::ADDR_LE_CNT, 16'h0005);
    ev(1'b1, 1'b0, 2);
    @(posedge ref_clk);
    reg_addr    <= svlc_pkg::ADDR_VIOL;
    reg_rd      <= 1'b1;
    viol_symbol <= 1'b1;
    @(posedge ref_clk);
    reg_rd      <= 1'b0;
    viol_symbol <= 1'b0;
    #1 chk("viol_race", 16'h0002, reg_rdata);
    rchk("viol_kept", svlc_pkg::ADDR_VIOL, 16'h0001);
    $display("test counters done");
    for (int r = 0; r < 4; r++)
    begin
      sel = (r < 2) ? 1'b1 : (r == 2) ? 1'b0 : 1'($urandom);
      n   = (r == 0) ? 17 : (r == 1) ? 14 : 12;
      foreach (g[i]) g[i] = (r < 2) ? 3'h7 : 3'($urandom);
      wr(svlc_pkg::ADDR_CTRL, 16'(sel) << svlc_pkg::CTRL_IDLE_SEL);
      rd(svlc_pkg::ADDR_IDLE, d);
      rd(svlc_pkg::ADDR_EVENTS, d);
      for (int i = 0; i < n; i++)
      begin
        @(posedge ref_clk);
        gap_valid <= 1'b1;
        gap_pairs <= g[i];
        @(posedge ref_clk);
        gap_valid <= 1'b0;
      end
      d = idle_exp(n, sel, e);
      rchk("idle_mon", svlc_pkg::ADDR_IDLE, d);
      evchk("ev_idle", svlc_pkg::EV_IDLE, e);
    end
    $display("test idle gap done");
    close_out();
  end
endmodule : testbench
